/* File: core/pdm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_cfg.svh"

module pdm_ctrl #(
	parameter int unsigned IRQW      = 16,
	parameter int unsigned ENTRY_CYC = `PDM_ENTRY_CYC
) (
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rstn_i,
	// Register port
	input  wire logic [7:0]      addr_i,
	input  wire logic [31:0]     wdata_i,
	input  wire logic            we_i,
	input  wire logic            re_i,
	output logic [31:0]          rdata_o,
	// CPU side
	input  wire logic [31:0]     pc_i,
	input  wire logic [IRQW-1:0] irq_i,
	output logic [31:0]          resume_pc_o,
	output logic                 resume_o,
	output logic                 isr_req_o,
	output pdm_pkg::pdm_mode_e   mode_o,
	// PLL side
	input  wire logic            pll_lock_i,
	output logic                 pll_enable_o,
	output logic                 pll_out_stop_o,
	output logic                 pll_in_stop_o,
	// Clock gates and freeze
	output logic                 cpu_clk_en_o,
	output logic                 intr_clk_en_o,
	output logic                 dma_clk_en_o,
	output logic                 io_freeze_o
);
	import pdm_pkg::*;

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------

	typedef struct packed {
		pdm_state_e      st;
		pdm_code_t       code;
		logic            global_interrupt_enable;
		logic [IRQW-1:0] mask;
		logic            pll_en;
		pdm_mode_e       pend;
		logic [31:0]     entry_pc;
		logic [31:0]     rdata;
		logic            resume;
		logic            isr;
	} pdm_ctrl_s;

	pdm_ctrl_s s_q;
	pdm_ctrl_s s_d;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	logic      wr_ctrl;
	logic      wr_mask;
	logic      wr_pll;
	logic      deep;
	logic      light;
	logic      tmr_start;
	logic      tmr_cancel;
	logic      tmr_done;
	logic      wake;
	logic      isr_hit;
	logic      nonmaskable_interrupt_enable;
	pdm_mode_e new_mode;
	pdm_mode_e act_mode;

	// Write decodes
	assign wr_ctrl = we_i && (addr_i == `PDM_OFS_CTRL);
	assign wr_mask = we_i && (addr_i == `PDM_OFS_IEMASK);
	assign wr_pll  = we_i && (addr_i == `PDM_OFS_PLLCS);

	// State classes
	assign deep  = (s_q.st == PDM_S_PLLOUT) || (s_q.st == PDM_S_PLLIN);
	assign light = (s_q.st == PDM_S_LIGHT);

	// code field of a control-word write
	assign new_mode = pdm_decode(wdata_i[`PDM_CODE_HI:`PDM_CODE_LO]);

	assign nonmaskable_interrupt_enable = s_q.mask[`PDM_NONMASKABLE_INTERRUPT_ENABLE_BIT];

	// reserved codes neither arm nor cancel a pending entry
	assign tmr_start  = wr_ctrl && !deep && !light && (new_mode != PDM_M_NONE);
	// writing zero drops a pending entry
	assign tmr_cancel = wr_ctrl && !deep && !light
		&& (wdata_i[`PDM_CODE_HI:`PDM_CODE_LO] == `PDM_CODE_NONE);

	// ------------------------------------------------------------
	// Entry delay
	// ------------------------------------------------------------

	// mode lands a fixed delay after the write
	pdm_entry_timer #(
		.CYC      (ENTRY_CYC)
	) u_timer (
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.start_i  (tmr_start),
		.cancel_i (tmr_cancel),
		.done_o   (tmr_done)
	);

	// ------------------------------------------------------------
	// Wake evaluation
	// ------------------------------------------------------------

	// Interrupt logic stays clocked, so wake is seen in light mode
	pdm_wake_eval #(
		.IRQW    (IRQW)
	) u_wake (
		.light_i (light),
		.any_i   (s_q.pend == PDM_M_LT_ANY),
		.irq_i   (irq_i),
		.mask_i  (s_q.mask),
		.gie_i   (s_q.global_interrupt_enable),
		.nonmaskable_interrupt_enable_i  (nonmaskable_interrupt_enable),
		.wake_o  (wake),
		.isr_o   (isr_hit)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	always_comb
	begin
		s_d        = s_q;
		s_d.resume = 1'b0;
		s_d.isr    = 1'b0;

		// Register writes; contents held untouched in deep modes
		// no write lands once a deep mode is active
		if (!deep)
		begin
			if (wr_ctrl)
			begin
				s_d.global_interrupt_enable = wdata_i[`PDM_GIE_BIT];
				// Code is only taken while running normally
				if (!light)
					s_d.code = wdata_i[`PDM_CODE_HI:`PDM_CODE_LO];
			end
			if (wr_mask)
				s_d.mask = wdata_i[IRQW-1:0];
			if (wr_pll)
				s_d.pll_en = wdata_i[`PDM_PLL_ENABLE_BIT_BIT];
		end

		// Read data, one cycle after the strobe
		s_d.rdata = 32'h0000_0000;
		if (re_i)
		begin
			case (addr_i)
				`PDM_OFS_CTRL:
				begin
					s_d.rdata[`PDM_CODE_HI:`PDM_CODE_LO] = s_q.code;
					s_d.rdata[`PDM_GIE_BIT] = s_q.global_interrupt_enable;
				end
				`PDM_OFS_IEMASK:
					s_d.rdata[IRQW-1:0] = s_q.mask;
				`PDM_OFS_PLLCS:
				begin
					s_d.rdata[`PDM_PLL_ENABLE_BIT_BIT] = s_q.pll_en;
					s_d.rdata[1] = pll_lock_i;
				end
				`PDM_OFS_STATUS:
				begin
					s_d.rdata[2:0] = 3'(s_q.st);
					s_d.rdata[6:4] = 3'(s_q.pend);
				end
				default:
					s_d.rdata = 32'h0000_0000;
			endcase
		end

		// Mode sequencing
		case (s_q.st)
			// hold the CPU until the PLL has relocked
			PDM_S_LOCK:
			begin
				if (pll_lock_i || !s_q.pll_en)
					s_d.st = PDM_S_RUN;
			end
			// normal running until a defined code arrives
			PDM_S_RUN:
			begin
				if (tmr_start)
				begin
					s_d.pend = new_mode;
					s_d.st   = PDM_S_ARM;
				end
			end
			PDM_S_ARM:
			begin
				if (tmr_start)
					s_d.pend = new_mode;
				else if (tmr_cancel)
				begin
					s_d.pend = PDM_M_NONE;
					s_d.st   = PDM_S_RUN;
				end
				else if (tmr_done)
				begin
					// remember where the mode took effect
					s_d.entry_pc = pc_i;
					case (s_q.pend)
						PDM_M_LT_EN,
						PDM_M_LT_ANY:
							s_d.st = PDM_S_LIGHT;
						PDM_M_PLLOUT:
							s_d.st = s_q.pll_en ? PDM_S_PLLOUT : PDM_S_RUN;
						PDM_M_PLLIN:
							s_d.st = s_q.pll_en ? PDM_S_PLLIN : PDM_S_RUN;
						default:
							s_d.st = PDM_S_RUN;
					endcase
					// Bypassed deep entry falls back to running, nothing pending
					if (s_d.st == PDM_S_RUN)
						s_d.pend = PDM_M_NONE;
				end
			end
			PDM_S_LIGHT:
			begin
				if (wake)
				begin
					s_d.isr    = isr_hit;
					// direct resume at the entry instruction
					s_d.resume = 1'b1;
					s_d.code   = `PDM_CODE_NONE;
					s_d.pend   = PDM_M_NONE;
					s_d.st     = PDM_S_RUN;
				end
			end
			PDM_S_PLLOUT,
			PDM_S_PLLIN:
				s_d.st = s_q.st;
			default:
				s_d.st = PDM_S_RUN;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Device reset is the only way out of the deep modes
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			s_q        <= '0;
			s_q.st     <= PDM_S_LOCK;
			s_q.code   <= `PDM_CODE_NONE;
			s_q.pll_en <= `PDM_RST_PLL_ENABLE_BIT;
			s_q.pend   <= PDM_M_NONE;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------

	// Mode in force, seen by the rest of the chip
	always_comb
	begin
		case (s_q.st)
			PDM_S_LIGHT:  act_mode = s_q.pend;
			PDM_S_PLLOUT: act_mode = PDM_M_PLLOUT;
			PDM_S_PLLIN:  act_mode = PDM_M_PLLIN;
			default:      act_mode = PDM_M_NONE;
		endcase
	end

	assign mode_o = act_mode;

	// Register values and answers
	assign rdata_o      = s_q.rdata;
	assign resume_pc_o  = s_q.entry_pc;
	assign resume_o     = s_q.resume;
	assign isr_req_o    = s_q.isr;
	assign pll_enable_o = s_q.pll_en;

	// CPU clock gated in light and deep modes, and in lock wait
	assign cpu_clk_en_o  = (s_q.st == PDM_S_RUN) || (s_q.st == PDM_S_ARM);
	// interrupt logic stays clocked in light mode
	assign intr_clk_en_o = !deep;
	// DMA engine keeps its clock in light mode
	assign dma_clk_en_o  = !deep;

	assign pll_out_stop_o = (s_q.st == PDM_S_PLLOUT);
	assign pll_in_stop_o  = (s_q.st == PDM_S_PLLIN);

	// synchronous functional outputs hold their last value
	// asynchronous peripherals ignore this freeze by design
	assign io_freeze_o = deep;

endmodule : pdm_ctrl

`default_nettype wire

/* File: core/pdm_cfg.svh */
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH

// Register offsets (byte addresses, one word each)
`define PDM_OFS_CTRL     8'h00
`define PDM_OFS_IEMASK   8'h04
`define PDM_OFS_PLLCS    8'h08
`define PDM_OFS_STATUS   8'h0c

// Field positions
`define PDM_CODE_HI      15
`define PDM_CODE_LO      10
`define PDM_GIE_BIT      0
`define PDM_NONMASKABLE_INTERRUPT_ENABLE_BIT     1
`define PDM_PLL_ENABLE_BIT_BIT    0

// Power-down code values
`define PDM_CODE_NONE    6'h00
`define PDM_CODE_LT_EN   6'h09
`define PDM_CODE_LT_ANY  6'h11
`define PDM_CODE_PLLOUT  6'h1a
`define PDM_CODE_PLLIN   6'h1c

// Reset values
`define PDM_RST_PLL_ENABLE_BIT    1'h1

// Cycles from the code write to the mode taking effect
`define PDM_ENTRY_CYC    9

`endif

/* File: core/pdm_pkg.sv */
`include "pdm_cfg.svh"

package pdm_pkg;

	// Controller states
	typedef enum logic [2:0] {
		PDM_S_LOCK,
		PDM_S_RUN,
		PDM_S_ARM,
		PDM_S_LIGHT,
		PDM_S_PLLOUT,
		PDM_S_PLLIN
	} pdm_state_e;

	// Decoded low-power modes
	typedef enum logic [2:0] {
		PDM_M_NONE,
		PDM_M_LT_EN,
		PDM_M_LT_ANY,
		PDM_M_PLLOUT,
		PDM_M_PLLIN
	} pdm_mode_e;

	typedef logic [5:0] pdm_code_t;

	// Code to mode; reserved codes fall to no mode
	function automatic pdm_mode_e pdm_decode(input pdm_code_t code);
		case (code)
			`PDM_CODE_LT_EN:  pdm_decode = PDM_M_LT_EN;
			`PDM_CODE_LT_ANY: pdm_decode = PDM_M_LT_ANY;
			`PDM_CODE_PLLOUT: pdm_decode = PDM_M_PLLOUT;
			`PDM_CODE_PLLIN:  pdm_decode = PDM_M_PLLIN;
			default:          pdm_decode = PDM_M_NONE;
		endcase
	endfunction : pdm_decode

endpackage : pdm_pkg

/* File: core/pdm_entry_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_cfg.svh"

module pdm_entry_timer #(
	parameter int unsigned CYC = `PDM_ENTRY_CYC
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// Control
	input  wire logic start_i,
	input  wire logic cancel_i,
	// Result
	output logic      done_o
);
	import pdm_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
	} pdm_tmr_s;

	pdm_tmr_s st_q;
	pdm_tmr_s st_d;

	// Done in the last counted cycle, so the mode lands on edge CYC
	assign done_o = (st_q.cnt == 8'h01) && !start_i && !cancel_i;

	// Down counter; a fresh start restarts the full delay
	always_comb
	begin
		st_d = st_q;
		if (cancel_i)
			st_d.cnt = 8'h00;
		else if (start_i)
			st_d.cnt = 8'(CYC);
		else if (st_q.cnt != 8'h00)
			st_d.cnt = st_q.cnt - 8'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

endmodule : pdm_entry_timer

`default_nettype wire

/* File: core/pdm_wake_eval.sv */
`timescale 1ns/1ps
`default_nettype none

module pdm_wake_eval #(
	parameter int unsigned IRQW = 16
) (
	// Active light mode and interrupt state
	input  wire logic            light_i,
	input  wire logic            any_i,
	input  wire logic [IRQW-1:0] irq_i,
	input  wire logic [IRQW-1:0] mask_i,
	input  wire logic            gie_i,
	input  wire logic            nonmaskable_interrupt_enable_i,
	// Verdict
	output logic                 wake_o,
	output logic                 isr_o
);
	import pdm_pkg::*;

	logic enabled_hit;
	logic any_hit;

	// Enabled means unmasked in the enable mask
	assign enabled_hit = |(irq_i & mask_i);
	assign any_hit     = |irq_i;

	// Wake and service decision
	always_comb
	begin
		wake_o = 1'b0;
		isr_o  = 1'b0;
		if (light_i)
		begin
			wake_o = any_i ? any_hit : enabled_hit;
			isr_o  = enabled_hit && gie_i && nonmaskable_interrupt_enable_i;
		end
	end

endmodule : pdm_wake_eval

`default_nettype wire

/* File: test/pdm_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_cfg.svh"

module pdm_ctrl_asserts #(
	parameter int unsigned IRQW      = 16,
	parameter int unsigned ENTRY_CYC = `PDM_ENTRY_CYC
) (
	// Clock and reset
	input wire logic               clk_i,
	input wire logic               rstn_i,
	// Register port
	input wire logic [7:0]         addr_i,
	input wire logic [31:0]        wdata_i,
	input wire logic               we_i,
	input wire logic               re_i,
	input wire logic [31:0]        rdata_o,
	// CPU side
	input wire logic [31:0]        pc_i,
	input wire logic [IRQW-1:0]    irq_i,
	input wire logic [31:0]        resume_pc_o,
	input wire logic               resume_o,
	input wire logic               isr_req_o,
	input wire pdm_pkg::pdm_mode_e mode_o,
	// PLL side
	input wire logic               pll_lock_i,
	input wire logic               pll_enable_o,
	input wire logic               pll_out_stop_o,
	input wire logic               pll_in_stop_o,
	// Clock gates and freeze
	input wire logic               cpu_clk_en_o,
	input wire logic               intr_clk_en_o,
	input wire logic               dma_clk_en_o,
	input wire logic               io_freeze_o
);
	import pdm_pkg::*;

	// ----------------------------------------
	// Helpers and clocking
	// ----------------------------------------
	localparam int DLY = ENTRY_CYC + 1;
	wire logic lt = (mode_o == PDM_M_LT_EN) || (mode_o == PDM_M_LT_ANY);
	wire logic deep = (mode_o == PDM_M_PLLOUT) || (mode_o == PDM_M_PLLIN);
	wire logic ctrl_wr = we_i && (addr_i == `PDM_OFS_CTRL);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_isr_pair; isr_req_o |-> resume_o; endproperty
	a_isr_pair: assert property (p_isr_pair) else $error("service request without resume");
	property p_resume_once; resume_o |=> !resume_o; endproperty
	a_resume_once: assert property (p_resume_once) else $error("resume longer than a pulse");
	property p_resume_src; resume_o |-> $past(lt); endproperty
	a_resume_src: assert property (p_resume_src) else $error("resume outside light mode");
	// Entry lands a fixed count after the control write
	property p_entry_delay; (mode_o != PDM_M_NONE && $past(mode_o) == PDM_M_NONE)
		|-> $past(ctrl_wr, DLY); endproperty
	a_entry_delay: assert property (p_entry_delay) else $error("mode entry delay wrong");
	property p_light_clk; lt |-> !cpu_clk_en_o && intr_clk_en_o && dma_clk_en_o; endproperty
	a_light_clk: assert property (p_light_clk) else $error("light mode clock gates wrong");
	property p_deep_freeze; (pll_out_stop_o || pll_in_stop_o)
		|-> io_freeze_o && !cpu_clk_en_o && !dma_clk_en_o; endproperty
	a_deep_freeze: assert property (p_deep_freeze) else $error("deep mode not frozen");
	property p_deep_stay; deep |=> $stable(mode_o) && !resume_o; endproperty
	a_deep_stay: assert property (p_deep_stay) else $error("deep mode left without reset");
	property p_any_wake; (mode_o == PDM_M_LT_ANY && irq_i != '0) |=> resume_o && cpu_clk_en_o;
	endproperty
	a_any_wake: assert property (p_any_wake) else $error("any interrupt did not wake");
	property p_quiet_stay; (lt && irq_i == '0) |=> lt && !resume_o; endproperty
	a_quiet_stay: assert property (p_quiet_stay) else $error("light mode left with no interrupt");
	property p_out_stop; pll_out_stop_o == (mode_o == PDM_M_PLLOUT); endproperty
	a_out_stop: assert property (p_out_stop) else $error("output stop mismatches mode");
	property p_in_stop; pll_in_stop_o == (mode_o == PDM_M_PLLIN); endproperty
	a_in_stop: assert property (p_in_stop) else $error("input stop mismatches mode");

	// Main scenarios reached
	c_isr: cover property (resume_o && isr_req_o);
	c_plain: cover property (resume_o && !isr_req_o);
	c_out: cover property (pll_out_stop_o);
	c_in: cover property (pll_in_stop_o);
endmodule : pdm_ctrl_asserts

bind pdm_ctrl pdm_ctrl_asserts #(.IRQW(IRQW), .ENTRY_CYC(ENTRY_CYC)) u_chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
	.re_i(re_i), .rdata_o(rdata_o), .pc_i(pc_i), .irq_i(irq_i), .resume_pc_o(resume_pc_o),
	.resume_o(resume_o), .isr_req_o(isr_req_o), .mode_o(mode_o), .pll_lock_i(pll_lock_i),
	.pll_enable_o(pll_enable_o), .pll_out_stop_o(pll_out_stop_o),
	.pll_in_stop_o(pll_in_stop_o), .cpu_clk_en_o(cpu_clk_en_o),
	.intr_clk_en_o(intr_clk_en_o), .dma_clk_en_o(dma_clk_en_o), .io_freeze_o(io_freeze_o)
);

`default_nettype wire

/* File: test/pdm_pll_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pdm_pll_model #(
	parameter int unsigned LOCK_CYC = 30
) (
	// Clock
	input  wire logic clk_i,
	// Control from the block
	input  wire logic enable_i,
	input  wire logic in_stop_i,
	// Lock flag
	output logic      lock_o
);
	// ----------------------------------------
	// Lock counter
	// ----------------------------------------
	int unsigned cnt_q;

	// relock after input stop
	// Bypass or stopped input loses lock, so a relock takes the full count
	always_ff @(posedge clk_i)
	begin
		if (!enable_i || in_stop_i)
			cnt_q <= 0;
		else if (cnt_q < LOCK_CYC)
			cnt_q <= cnt_q + 1;
	end
	assign lock_o = (cnt_q >= LOCK_CYC);
endmodule : pdm_pll_model

`default_nettype wire

/* File: test/pdm_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_cfg.svh"

module pdm_ctrl_bench;
	import pdm_pkg::*;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam int unsigned IRQW = 16;
	logic            clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, lock;
	logic [7:0]      addr = '0;
	logic [31:0]     wdata = '0, pc = 32'h100, rdata, rpc;
	logic [IRQW-1:0] irq = '0;
	logic            resume, isr, pll_en, out_stop, in_stop, cpu_en, intr_en, dma_en, frz;
	pdm_mode_e       mode;
	int              mismatches = 0;
	int              compares = 0;

	pdm_ctrl #(.IRQW(IRQW), .ENTRY_CYC(`PDM_ENTRY_CYC)) u_dut (
		.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
		.rdata_o(rdata), .pc_i(pc), .irq_i(irq), .resume_pc_o(rpc), .resume_o(resume),
		.isr_req_o(isr), .mode_o(mode), .pll_lock_i(lock), .pll_enable_o(pll_en),
		.pll_out_stop_o(out_stop), .pll_in_stop_o(in_stop), .cpu_clk_en_o(cpu_en),
		.intr_clk_en_o(intr_en), .dma_clk_en_o(dma_en), .io_freeze_o(frz));
	pdm_pll_model #(.LOCK_CYC(30)) u_pll (.clk_i(clk), .enable_i(pll_en),
		.in_stop_i(in_stop), .lock_o(lock));

	// 200 MHz clock
	initial forever #2.5 clk = ~clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask : rd

	// Reset, then count cycles until the CPU clock runs
	task automatic do_reset(output int n);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		for (n = 0; n < 100 && cpu_en !== 1'b1; n++)
			tick(1);
	endtask : do_reset

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] v;
		int n;
		do_reset(n);
		check(n > 10, 1);
		check(pll_en, 1);
		rd(`PDM_OFS_PLLCS, v);
		check(v[0], 1);
		rd(8'h10, v);
		check(v, 0);
		check(mode, PDM_M_NONE);
		$display("test reset done");
	endtask : t_reset

	task automatic t_light(input pdm_code_t c, input logic g, input logic [31:0] m,
		input logic [IRQW-1:0] iv, input logic ei, input pdm_mode_e em);
		@(posedge clk);
		pc <= 32'h200 + c;
		wr(`PDM_OFS_IEMASK, m);
		wr(`PDM_OFS_CTRL, {16'h0, c, 9'h0, g});
		tick(8);
		check(mode, PDM_M_NONE);
		tick(1);
		check(mode, em);
		check({cpu_en, intr_en, dma_en}, 3'b011);
		check(rpc, 32'h200 + c);
		// Non-enabled line must leave the enabled-only mode asleep
		if (em == PDM_M_LT_EN)
		begin
			@(posedge clk);
			irq <= 16'h8000;
			tick(3);
			check({mode, resume}, {em, 1'b0});
		end
		@(posedge clk);
		irq <= iv;
		for (int n = 0; n < 5 && resume !== 1'b1; n++)
			tick(1);
		check(resume, 1);
		check(isr, ei);
		check({mode, cpu_en}, {PDM_M_NONE, 1'b1});
		tick(1);
		check(resume, 0);
		@(posedge clk);
		irq <= '0;
		$display("test light %h done", c);
	endtask : t_light

	task automatic t_reserved();
		logic [31:0] v;
		pdm_code_t   codes [3] = '{6'h21, 6'h05, 6'h3f};
		foreach (codes[i])
		begin
			wr(`PDM_OFS_CTRL, {16'h0, codes[i], 10'h0});
			tick(12);
			check({mode, cpu_en}, {PDM_M_NONE, 1'b1});
		end
		rd(`PDM_OFS_STATUS, v);
		check(v[2:0], 1);
		$display("test reserved done");
	endtask : t_reserved

	task automatic t_bypass();
		wr(`PDM_OFS_PLLCS, 32'h0);
		wr(`PDM_OFS_CTRL, {16'h0, `PDM_CODE_PLLOUT, 10'h0});
		tick(12);
		check({out_stop, cpu_en, frz}, 3'b010);
		wr(`PDM_OFS_PLLCS, 32'h1);
		tick(32);
		$display("test bypass done");
	endtask : t_bypass

	task automatic t_deep(input pdm_code_t c, input pdm_mode_e em);
		int n;
		wr(`PDM_OFS_PLLCS, 32'h1);
		wr(`PDM_OFS_CTRL, {16'h0, c, 10'h0});
		tick(9);
		check(mode, em);
		check({out_stop, in_stop}, {c == `PDM_CODE_PLLOUT, c == `PDM_CODE_PLLIN});
		check({frz, cpu_en, dma_en}, 3'b100);
		@(posedge clk);
		irq <= '1;
		wr(`PDM_OFS_CTRL, 32'h0);
		tick(5);
		check({mode, resume}, {em, 1'b0});
		@(posedge clk);
		irq <= '0;
		do_reset(n);
		check(n > 10, c == `PDM_CODE_PLLIN);
		check(mode, PDM_M_NONE);
		$display("test deep %h done", c);
	endtask : t_deep

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		t_reset();
		t_light(`PDM_CODE_LT_EN, 1'b1, 32'h3, 16'h1, 1'b1, PDM_M_LT_EN);
		t_light(`PDM_CODE_LT_EN, 1'b0, 32'h3, 16'h1, 1'b0, PDM_M_LT_EN);
		t_light(`PDM_CODE_LT_EN, 1'b1, 32'h1, 16'h1, 1'b0, PDM_M_LT_EN);
		t_light(`PDM_CODE_LT_ANY, 1'b1, 32'h3, 16'h4, 1'b0, PDM_M_LT_ANY);
		t_light(`PDM_CODE_LT_ANY, 1'b1, 32'h3, 16'h1, 1'b1, PDM_M_LT_ANY);
		t_reserved();
		t_bypass();
		t_deep(`PDM_CODE_PLLOUT, PDM_M_PLLOUT);
		t_deep(`PDM_CODE_PLLIN, PDM_M_PLLIN);
		give_verdict();
	end

	// Tests need well under a thousand cycles
	initial
	begin
		#25000;
		mismatches++;
		give_verdict();
	end
endmodule : pdm_ctrl_bench

`default_nettype wire
